/* File: inc/obc_pkg.sv */
// shared constants for the debug break control link and both of its ends
package obc_pkg;
  // ****************************************
  // frame layout
  // ****************************************
  localparam int FRAME_W = 24;
  localparam int SEQ_W = 25;
  localparam int ADDR_W = 16;
  localparam int NUM_BP = 4;
  localparam int CMD_LSB = 20;
  localparam int IDX_LSB = 18;
  localparam int EN_BIT = 17;
  localparam int KIND_BIT = 16;
  localparam int RSP_HALT_BIT = 23;
  localparam int RSP_SW_BIT = 22;
  // ****************************************
  // commands
  // ****************************************
  localparam logic [3:0] CMD_NOP = 4'h0;
  localparam logic [3:0] CMD_SET_BP = 4'h1;
  localparam logic [3:0] CMD_START = 4'h2;
  localparam logic [3:0] CMD_READ_IO = 4'h3;
  localparam logic [3:0] UCMD_STEP = 4'h4;
  localparam logic [1:0] STEP_BP = 2'h3;
  localparam logic KIND_FETCH = 1'b0;
  // ****************************************
  // link timing and reset values
  // ****************************************
  localparam logic [4:0] RESET_EDGES = 5'h05;
  localparam logic [4:0] FRAME_EDGES = 5'h19;
  localparam logic [4:0] FRAME_BITS = 5'h18;
  localparam int TCK_HALF_CYC = 8;
  localparam logic [3:0] DEV_PIN_RST = 4'h8;
  localparam logic [1:0] PRB_PIN_RST = 2'h3;
  localparam logic [15:0] SKIP_IO_ADDR = 16'h000c;
endpackage

/* File: inc/obc_link_if.sv */
// four-wire scan link plus open-drain system reset between probe and device
`timescale 1ns/100ps
`default_nettype none
interface obc_link_if;
  logic tck;
  logic tms;
  logic tdi;
  logic tdo_o;
  logic tdo_oe;
  logic srst_o;
  logic srst_oe;
  logic tdo;
  logic srst_n;
  // pull-ups resolve undriven wires
  assign tdo = tdo_oe ? tdo_o : 1'b1;
  assign srst_n = ~(srst_oe & ~srst_o);
  modport probe (output tck, output tms, output tdi, output srst_o, output srst_oe,
    input tdo, input srst_n);
  modport dev (input tck, input tms, input tdi, input srst_n,
    output tdo_o, output tdo_oe);
endinterface
`default_nettype wire

/* File: hdl/obc_dev_end.sv */
// device end: break, resume, hardware compare and scan frame decoding
`timescale 1ns/100ps
`default_nettype none
module obc_dev_end #(
  parameter int NUM_BP = obc_pkg::NUM_BP
) (
  input wire logic I_CLK_SYS,
  input wire logic I_RSTN,
  obc_link_if.dev link,
  input wire logic I_FETCH_VALID,
  input wire logic [15:0] I_FETCH_ADDR,
  input wire logic I_FETCH_IS_BREAK,
  input wire logic I_DATA_VALID,
  input wire logic [15:0] I_DATA_ADDR,
  input wire logic I_CSR_WR,
  input wire logic I_CSR_DISABLE,
  input wire logic [7:0] I_IO_RD_DATA,
  output logic O_CORE_HALT,
  output logic O_EXEC_DISPLACED,
  output logic O_IO_RD_REQ,
  output logic [15:0] O_IO_RD_ADDR,
  output logic O_PERIPH_CLK_EN,
  output logic O_CORE_RESET,
  output logic O_SCAN_PORT_DISABLE
);
  typedef enum logic [1:0] {
    RUN = 2'b01,
    HALT = 2'b10
  } obc_run_e;

  // ****************************************
  // state
  // ****************************************
  logic [3:0] s1_reg, s2_reg, s3_reg, flt_reg;
  logic [3:0] s1_next, s2_next, s3_next, flt_next;
  logic tck_prev_reg, tck_prev_next;
  logic [2:0] hi_cnt_reg, hi_cnt_next;
  logic [4:0] bit_cnt_reg, bit_cnt_next;
  logic [23:0] rx_reg, rx_next;
  logic [23:0] tx_reg, tx_next;
  logic tdo_reg, tdo_next;
  logic tdo_oe_reg, tdo_oe_next;
  logic [15:0] bp_addr_reg [NUM_BP];
  logic [15:0] bp_addr_next [NUM_BP];
  logic [NUM_BP-1:0] bp_en_reg, bp_en_next;
  logic [NUM_BP-1:0] bp_kind_reg, bp_kind_next;
  obc_run_e st_reg, st_next;
  logic sw_reg, sw_next;
  logic disp_reg, disp_next;
  logic rd_req_reg, rd_req_next;
  logic [15:0] rd_addr_reg, rd_addr_next;
  logic [15:0] rsp_data_reg, rsp_data_next;
  logic dis_reg, dis_next;
  logic core_rst_reg, core_rst_next;
  logic periph_reg, periph_next;

  // any enabled register of the given access kind at this address
  function automatic logic bp_hit(input logic [15:0] addr, input logic kind,
    input logic [NUM_BP-1:0] en, input logic [NUM_BP-1:0] knd,
    input logic [15:0] tab [NUM_BP]);
    logic hit;
    hit = 1'b0;
    for (int i = 0; i < NUM_BP; i++) begin
      if (en[i] && knd[i] == kind && tab[i] == addr) begin
        hit = 1'b1;
      end
    end
    return hit;
  endfunction

  // ****************************************
  // next state
  // ****************************************
  always_comb begin
    logic tck_rise;
    logic tms_b;
    logic commit;
    logic [23:0] word;
    logic [23:0] rsp;
    logic [1:0] idx;
    tck_rise = 1'b0;
    tms_b = 1'b0;
    commit = 1'b0;
    word = rx_reg;
    rsp = 24'h000000;
    idx = 2'h0;
    // three-stage synchroniser; a change counts when stages two and three agree
    s1_next = {link.srst_n, link.tck, link.tms, link.tdi};
    s2_next = s1_reg;
    s3_next = s2_reg;
    flt_next = (s2_reg & s3_reg) | (flt_reg & (s2_reg ^ s3_reg));
    tck_prev_next = flt_reg[2];
    hi_cnt_next = hi_cnt_reg;
    bit_cnt_next = bit_cnt_reg;
    rx_next = rx_reg;
    tx_next = tx_reg;
    bp_addr_next = bp_addr_reg;
    bp_en_next = bp_en_reg;
    bp_kind_next = bp_kind_reg;
    st_next = st_reg;
    sw_next = sw_reg;
    disp_next = 1'b0;
    rd_req_next = 1'b0;
    rd_addr_next = rd_addr_reg;
    rsp_data_next = rsp_data_reg;
    dis_next = dis_reg;
    core_rst_next = ~flt_reg[3];
    periph_next = 1'b1;
    rsp[obc_pkg::RSP_HALT_BIT] = (st_reg == HALT);
    rsp[obc_pkg::RSP_SW_BIT] = sw_reg;
    rsp[15:0] = rsp_data_reg;
    if (rd_req_reg) begin
      rsp_data_next = {8'h00, I_IO_RD_DATA};
    end
    // the core register bit; a reset or a register write with I_CSR_DISABLE low clears it
    if (!flt_reg[3]) begin
      dis_next = 1'b0;
    end else if (I_CSR_WR) begin
      dis_next = I_CSR_DISABLE;
    end
    tck_rise = flt_reg[2] & ~tck_prev_reg & ~dis_reg;
    tms_b = flt_reg[1];
    if (tck_rise) begin
      if (tms_b) begin
        if (hi_cnt_reg != 3'h7) begin
          hi_cnt_next = hi_cnt_reg + 3'h1;
        end
        commit = (bit_cnt_reg == obc_pkg::FRAME_BITS) && (hi_cnt_reg == 3'h0);
        if (commit || {2'h0, hi_cnt_reg} >= obc_pkg::RESET_EDGES - 5'h01) begin
          bit_cnt_next = 5'h00;
        end
      end else begin
        hi_cnt_next = 3'h0;
        if (bit_cnt_reg != obc_pkg::FRAME_BITS) begin
          bit_cnt_next = bit_cnt_reg + 5'h01;
          rx_next = {flt_reg[0], rx_reg[23:1]};
          tx_next = {1'b0, (bit_cnt_reg == 5'h00) ? rsp[23:1] : tx_reg[23:1]};
        end
      end
    end
    // between frames the shifter always holds the live response
    if (bit_cnt_next == 5'h00) begin
      tx_next = rsp;
    end
    idx = word[obc_pkg::IDX_LSB +: 2];
    if (commit) begin
      case (word[obc_pkg::CMD_LSB +: 4])
        obc_pkg::CMD_SET_BP: begin
          bp_addr_next[idx] = word[15:0];
          bp_en_next[idx] = word[obc_pkg::EN_BIT];
          bp_kind_next[idx] = word[obc_pkg::KIND_BIT];
        end
        obc_pkg::CMD_READ_IO: begin
          rd_req_next = 1'b1;
          rd_addr_next = word[15:0];
        end
        default: begin
        end
      endcase
    end
    case (st_reg)
      RUN: begin
        if (I_FETCH_VALID && I_FETCH_IS_BREAK) begin
          st_next = HALT;
          sw_next = 1'b1;
        end else if ((I_FETCH_VALID && bp_hit(I_FETCH_ADDR, obc_pkg::KIND_FETCH,
            bp_en_reg, bp_kind_reg, bp_addr_reg)) || (I_DATA_VALID &&
            bp_hit(I_DATA_ADDR, ~obc_pkg::KIND_FETCH, bp_en_reg, bp_kind_reg,
            bp_addr_reg))) begin
          st_next = HALT;
          sw_next = 1'b0;
        end
      end
      HALT: begin
        if (commit && word[obc_pkg::CMD_LSB +: 4] == obc_pkg::CMD_START) begin
          st_next = RUN;
          disp_next = sw_reg;
        end
      end
      default: begin
        st_next = RUN;
      end
    endcase
    // a system reset restarts the core out of any halt
    if (!flt_reg[3]) begin
      st_next = RUN;
      sw_next = 1'b0;
    end
    tdo_next = tx_next[0];
    tdo_oe_next = ~dis_next;
  end

  // ****************************************
  // registers
  // ****************************************
  always_ff @(posedge I_CLK_SYS or negedge I_RSTN) begin
    if (!I_RSTN) begin
      s1_reg <= obc_pkg::DEV_PIN_RST;
      s2_reg <= obc_pkg::DEV_PIN_RST;
      s3_reg <= obc_pkg::DEV_PIN_RST;
      flt_reg <= obc_pkg::DEV_PIN_RST;
      tck_prev_reg <= 1'b0;
      hi_cnt_reg <= 3'h0;
      bit_cnt_reg <= 5'h00;
      rx_reg <= 24'h000000;
      tx_reg <= 24'h000000;
      tdo_reg <= 1'b0;
      tdo_oe_reg <= 1'b0;
      for (int i = 0; i < NUM_BP; i++) begin
        bp_addr_reg[i] <= 16'h0000;
      end
      bp_en_reg <= '0;
      bp_kind_reg <= '0;
      st_reg <= RUN;
      sw_reg <= 1'b0;
      disp_reg <= 1'b0;
      rd_req_reg <= 1'b0;
      rd_addr_reg <= 16'h0000;
      rsp_data_reg <= 16'h0000;
      dis_reg <= 1'b0;
      core_rst_reg <= 1'b0;
      periph_reg <= 1'b1;
    end else begin
      s1_reg <= s1_next;
      s2_reg <= s2_next;
      s3_reg <= s3_next;
      flt_reg <= flt_next;
      tck_prev_reg <= tck_prev_next;
      hi_cnt_reg <= hi_cnt_next;
      bit_cnt_reg <= bit_cnt_next;
      rx_reg <= rx_next;
      tx_reg <= tx_next;
      tdo_reg <= tdo_next;
      tdo_oe_reg <= tdo_oe_next;
      bp_addr_reg <= bp_addr_next;
      bp_en_reg <= bp_en_next;
      bp_kind_reg <= bp_kind_next;
      st_reg <= st_next;
      sw_reg <= sw_next;
      disp_reg <= disp_next;
      rd_req_reg <= rd_req_next;
      rd_addr_reg <= rd_addr_next;
      rsp_data_reg <= rsp_data_next;
      dis_reg <= dis_next;
      core_rst_reg <= core_rst_next;
      periph_reg <= periph_next;
    end
  end

  // ****************************************
  // outputs
  // ****************************************
  assign link.tdo_o = tdo_reg;
  assign link.tdo_oe = tdo_oe_reg;
  assign O_CORE_HALT = (st_reg == HALT);
  assign O_EXEC_DISPLACED = disp_reg;
  assign O_IO_RD_REQ = rd_req_reg;
  assign O_IO_RD_ADDR = rd_addr_reg;
  assign O_PERIPH_CLK_EN = periph_reg;
  assign O_CORE_RESET = core_rst_reg;
  assign O_SCAN_PORT_DISABLE = dis_reg;
endmodule
`default_nettype wire

/* File: hdl/obc_probe_end.sv */
// probe end: clock divider, frame sequencing and system reset drive
`timescale 1ns/100ps
`default_nettype none
module obc_probe_end #(
  parameter int TCK_HALF = obc_pkg::TCK_HALF_CYC
) (
  input wire logic I_CLK_SYS,
  input wire logic I_RSTN,
  obc_link_if.probe link,
  input wire logic I_CMD_VALID,
  input wire logic [3:0] I_CMD,
  input wire logic [1:0] I_IDX,
  input wire logic I_EN,
  input wire logic I_KIND,
  input wire logic [15:0] I_ADDR,
  input wire logic I_HOLD_RESET,
  output logic O_CMD_READY,
  output logic O_CMD_REFUSED,
  output logic O_RESP_VALID,
  output logic [23:0] O_RESP,
  output logic O_SRST_SENSED
);
  typedef enum logic [2:0] {
    IDLE = 3'b001,
    LOW = 3'b010,
    HIGH = 3'b100
  } obc_prb_e;

  obc_prb_e st_reg, st_next;
  logic [1:0] s1_reg, s2_reg, s3_reg, flt_reg;
  logic [1:0] s1_next, s2_next, s3_next, flt_next;
  logic [7:0] div_reg, div_next;
  logic tck_reg, tck_next;
  logic [24:0] tms_reg, tms_next, tdi_reg, tdi_next;
  logic [4:0] edges_reg, edges_next;
  logic frame_reg, frame_next;
  logic rst_pend_reg, rst_pend_next;
  logic pend_reg, pend_next;
  logic [23:0] pend_word_reg, pend_word_next;
  logic [23:0] rx_reg, rx_next;
  logic rdy_reg, rdy_next;
  logic ref_reg, ref_next;
  logic rv_reg, rv_next;
  logic srst_oe_reg, srst_oe_next;

  always_comb begin
    logic tick;
    logic [23:0] word;
    logic load;
    tick = (div_reg == 8'(TCK_HALF - 1));
    word = {I_CMD, I_IDX, I_EN, I_KIND, I_ADDR};
    load = 1'b0;
    s1_next = {link.srst_n, link.tdo};
    s2_next = s1_reg;
    s3_next = s2_reg;
    flt_next = (s2_reg & s3_reg) | (flt_reg & (s2_reg ^ s3_reg));
    st_next = st_reg;
    div_next = (st_reg == IDLE || tick) ? 8'h00 : div_reg + 8'h01;
    tck_next = tck_reg;
    tms_next = tms_reg;
    tdi_next = tdi_reg;
    edges_next = edges_reg;
    frame_next = frame_reg;
    rst_pend_next = rst_pend_reg;
    pend_next = pend_reg;
    pend_word_next = pend_word_reg;
    rx_next = rx_reg;
    ref_next = 1'b0;
    rv_next = 1'b0;
    srst_oe_next = I_HOLD_RESET;
    case (st_reg)
      IDLE: begin
        if (rst_pend_reg) begin
          tms_next = '1;
          tdi_next = '0;
          edges_next = obc_pkg::RESET_EDGES;
          frame_next = 1'b0;
          rst_pend_next = 1'b0;
          st_next = LOW;
        end else if (pend_reg) begin
          word = pend_word_reg;
          pend_next = 1'b0;
          load = 1'b1;
        end else if (I_CMD_VALID && rdy_reg) begin
          if ((I_CMD == obc_pkg::CMD_SET_BP && I_IDX == obc_pkg::STEP_BP) ||
              (I_CMD == obc_pkg::CMD_READ_IO && I_ADDR == obc_pkg::SKIP_IO_ADDR)) begin
            ref_next = 1'b1;
          end else if (I_CMD == obc_pkg::UCMD_STEP) begin
            // step: aim the reserved compare at the target, then start
            word = {obc_pkg::CMD_SET_BP, obc_pkg::STEP_BP, 1'b1, obc_pkg::KIND_FETCH,
              I_ADDR};
            pend_next = 1'b1;
            pend_word_next = {obc_pkg::CMD_START, 20'h00000};
            load = 1'b1;
          end else begin
            load = 1'b1;
          end
        end
        if (load) begin
          tms_next = {1'b1, 24'h000000};
          tdi_next = {1'b0, word};
          edges_next = obc_pkg::FRAME_EDGES;
          frame_next = 1'b1;
          st_next = LOW;
        end
      end
      LOW: begin
        if (tick) begin
          tck_next = 1'b1;
          // sampled just before the rising edge; single device, no bypass bits
          if (!tms_reg[0]) begin
            rx_next = {flt_reg[0], rx_reg[23:1]};
          end
          st_next = HIGH;
        end
      end
      HIGH: begin
        if (tick) begin
          tck_next = 1'b0;
          tms_next = {1'b0, tms_reg[24:1]};
          tdi_next = {1'b0, tdi_reg[24:1]};
          edges_next = edges_reg - 5'h01;
          if (edges_reg == 5'h01) begin
            st_next = IDLE;
            tms_next = '0;
            rv_next = frame_reg;
          end else begin
            st_next = LOW;
          end
        end
      end
      default: begin
        st_next = IDLE;
      end
    endcase
    rdy_next = (st_next == IDLE) && !rst_pend_next && !pend_next && !ref_next;
  end

  always_ff @(posedge I_CLK_SYS or negedge I_RSTN) begin
    if (!I_RSTN) begin
      st_reg <= IDLE;
      s1_reg <= obc_pkg::PRB_PIN_RST;
      s2_reg <= obc_pkg::PRB_PIN_RST;
      s3_reg <= obc_pkg::PRB_PIN_RST;
      flt_reg <= obc_pkg::PRB_PIN_RST;
      div_reg <= 8'h00;
      tck_reg <= 1'b0;
      tms_reg <= '0;
      tdi_reg <= '0;
      edges_reg <= 5'h00;
      frame_reg <= 1'b0;
      rst_pend_reg <= 1'b1;
      pend_reg <= 1'b0;
      pend_word_reg <= 24'h000000;
      rx_reg <= 24'h000000;
      rdy_reg <= 1'b0;
      ref_reg <= 1'b0;
      rv_reg <= 1'b0;
      srst_oe_reg <= 1'b0;
    end else begin
      st_reg <= st_next;
      s1_reg <= s1_next;
      s2_reg <= s2_next;
      s3_reg <= s3_next;
      flt_reg <= flt_next;
      div_reg <= div_next;
      tck_reg <= tck_next;
      tms_reg <= tms_next;
      tdi_reg <= tdi_next;
      edges_reg <= edges_next;
      frame_reg <= frame_next;
      rst_pend_reg <= rst_pend_next;
      pend_reg <= pend_next;
      pend_word_reg <= pend_word_next;
      rx_reg <= rx_next;
      rdy_reg <= rdy_next;
      ref_reg <= ref_next;
      rv_reg <= rv_next;
      srst_oe_reg <= srst_oe_next;
    end
  end

  assign link.tck = tck_reg;
  assign link.tms = tms_reg[0];
  assign link.tdi = tdi_reg[0];
  assign link.srst_o = 1'b0;
  assign link.srst_oe = srst_oe_reg;
  assign O_CMD_READY = rdy_reg;
  assign O_CMD_REFUSED = ref_reg;
  assign O_RESP_VALID = rv_reg;
  assign O_RESP = rx_reg;
  assign O_SRST_SENSED = ~flt_reg[1];
endmodule
`default_nettype wire

/* File: verif/obc_assertions.sv */
// assertions on the link wires and the device end's core signals
`timescale 1ns/100ps
`default_nettype none
module obc_assertions (
  input wire logic I_CLK_SYS,
  input wire logic I_RSTN,
  input wire logic tms,
  input wire logic tdo_oe,
  input wire logic srst_n,
  input wire logic I_FETCH_VALID,
  input wire logic I_FETCH_IS_BREAK,
  input wire logic I_CSR_WR,
  input wire logic I_CSR_DISABLE,
  input wire logic O_CORE_HALT,
  input wire logic O_EXEC_DISPLACED,
  input wire logic O_PERIPH_CLK_EN,
  input wire logic O_CORE_RESET,
  input wire logic O_SCAN_PORT_DISABLE
);
  // ****************************************
  // cycles since mode select was last high
  // ****************************************
  logic [5:0] tms_age_reg;
  logic [5:0] tms_age_next;
  always_comb begin
    tms_age_next = tms_age_reg;
    if (tms) begin
      tms_age_next = 6'h00;
    end else if (tms_age_reg != 6'h3f) begin
      tms_age_next = tms_age_reg + 6'h01;
    end
  end
  always_ff @(posedge I_CLK_SYS or negedge I_RSTN) begin
    if (!I_RSTN) begin
      tms_age_reg <= 6'h3f;
    end else begin
      tms_age_reg <= tms_age_next;
    end
  end
  // ****************************************
  // properties
  // ****************************************
  default clocking @(posedge I_CLK_SYS); endclocking
  default disable iff (!I_RSTN);
  sequence resume_s;
    $fell(O_CORE_HALT) ##1 !O_EXEC_DISPLACED;
  endsequence
  periph_clk_on_a: assert property (O_PERIPH_CLK_EN)
    else $error("peripheral clock enable dropped");
  sw_break_halt_a: assert property (I_FETCH_VALID && I_FETCH_IS_BREAK && !O_CORE_HALT
    && srst_n && !O_CORE_RESET |=> O_CORE_HALT) else $error("break fetch did not halt");
  halt_release_a: assert property ($fell(O_CORE_HALT) |-> tms_age_reg < 6'h28
    || O_CORE_RESET || $past(O_CORE_RESET)) else $error("halt left without a commit");
  displaced_pulse_a: assert property (O_EXEC_DISPLACED |-> resume_s)
    else $error("displaced pulse not tied to resume");
  disable_set_a: assert property (I_CSR_WR && I_CSR_DISABLE && srst_n && !O_CORE_RESET
    |=> O_SCAN_PORT_DISABLE) else $error("disable bit not set");
  disable_clear_a: assert property ($fell(O_SCAN_PORT_DISABLE)
    |-> O_CORE_RESET || $past(O_CORE_RESET)) else $error("disable bit cleared without reset");
  disabled_quiet_a: assert property (O_SCAN_PORT_DISABLE ##1 O_SCAN_PORT_DISABLE
    |-> !tdo_oe) else $error("data out driven while disabled");
  reset_tracks_a: assert property (!srst_n [*6] |-> O_CORE_RESET)
    else $error("core reset not following reset line");
  reset_release_a: assert property (srst_n [*6] |-> !O_CORE_RESET)
    else $error("core reset stuck after release");
endmodule
`default_nettype wire

/* File: verif/ocd_break_control_tb_top.sv */
// self-checking bench joining probe end and device end
`timescale 1ns/100ps
`default_nettype none
module ocd_break_control_tb_top;
  logic clk, rstn, fv, fb, dv, cw, cd, cv, en, kd, hold, r;
  logic [15:0] fa, da, ad, a;
  logic [7:0] iod;
  logic [3:0] cmd;
  logic [1:0] idx;
  logic halt, disp, iorq, pclk, crst, dis, rdy, refd, rv, sens;
  logic [15:0] ioa;
  logic [23:0] resp, shifted;
  logic [31:0] seed;
  int num_errors, samples_checked, disp_cnt, iorq_cnt, rst_edges, d0;
  bit seen_rdy;
  obc_link_if link ();
  obc_dev_end obc_dev_end_i (.I_CLK_SYS(clk), .I_RSTN(rstn), .link(link), .I_FETCH_VALID(fv),
    .I_FETCH_ADDR(fa), .I_FETCH_IS_BREAK(fb), .I_DATA_VALID(dv), .I_DATA_ADDR(da),
    .I_CSR_WR(cw), .I_CSR_DISABLE(cd), .I_IO_RD_DATA(iod), .O_CORE_HALT(halt),
    .O_EXEC_DISPLACED(disp), .O_IO_RD_REQ(iorq), .O_IO_RD_ADDR(ioa), .O_PERIPH_CLK_EN(pclk),
    .O_CORE_RESET(crst), .O_SCAN_PORT_DISABLE(dis));
  obc_probe_end obc_probe_end_i (.I_CLK_SYS(clk), .I_RSTN(rstn), .link(link),
    .I_CMD_VALID(cv), .I_CMD(cmd), .I_IDX(idx), .I_EN(en), .I_KIND(kd), .I_ADDR(ad),
    .I_HOLD_RESET(hold), .O_CMD_READY(rdy), .O_CMD_REFUSED(refd), .O_RESP_VALID(rv),
    .O_RESP(resp), .O_SRST_SENSED(sens));
  obc_assertions obc_assertions_i (.I_CLK_SYS(clk), .I_RSTN(rstn), .tms(link.tms),
    .tdo_oe(link.tdo_oe), .srst_n(link.srst_n), .I_FETCH_VALID(fv), .I_FETCH_IS_BREAK(fb),
    .I_CSR_WR(cw), .I_CSR_DISABLE(cd), .O_CORE_HALT(halt), .O_EXEC_DISPLACED(disp),
    .O_PERIPH_CLK_EN(pclk), .O_CORE_RESET(crst), .O_SCAN_PORT_DISABLE(dis));
  initial clk = 1'b0;
  always #20 clk = ~clk;
  // ****************************************
  // wire monitors
  // ****************************************
  always @(posedge link.tck) begin
    if (link.tms === 1'b1 && !seen_rdy) rst_edges++;
    if (link.tms === 1'b0) shifted = {link.tdi, shifted[23:1]};
  end
  always @(posedge clk) begin
    if (rdy === 1'b1) seen_rdy = 1'b1;
    if (disp === 1'b1) disp_cnt++;
    if (iorq === 1'b1) iorq_cnt++;
  end
  // ****************************************
  // helpers
  // ****************************************
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  function automatic logic [23:0] frame_word(input logic [3:0] c, input logic [1:0] i,
      input logic e, input logic k, input logic [15:0] x);
    return {c, i, e, k, x};
  endfunction
  task automatic print_verdict();
    $display("checks %0d errors %0d", samples_checked, num_errors);
    if (num_errors == 0 && samples_checked > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  task automatic check(input logic [23:0] seen, input logic [23:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      num_errors++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  // one request, held from the negedge before its taking edge until taken
  task automatic send(input logic [3:0] c, input logic [1:0] i, input logic e,
      input logic k, input logic [15:0] x, output logic got_ref);
    int n;
    n = 0;
    got_ref = 1'b0;
    @(negedge clk);
    while (rdy !== 1'b1) begin
      @(negedge clk);
      n++;
      if (n > 3000) begin
        num_errors++;
        print_verdict();
      end
    end
    cv = 1'b1; cmd = c; idx = i; en = e; kd = k; ad = x;
    @(negedge clk);
    cv = 1'b0;
    // a step answers once per frame; only the second frame's answer ends it
    repeat ((c == obc_pkg::UCMD_STEP) ? 2 : 1) begin
      if (rv === 1'b1) @(negedge clk);
      n = 0;
      while (rv !== 1'b1 && !got_ref) begin
        if (refd === 1'b1) got_ref = 1'b1;
        if (!got_ref) @(negedge clk);
        n++;
        if (n > 3000) begin
          num_errors++;
          print_verdict();
        end
      end
    end
    if (!got_ref && c != obc_pkg::UCMD_STEP) check(shifted, frame_word(c, i, e, k, x));
  endtask
  // one access cycle: fetch when k is 0, data access when k is 1
  task automatic hit(input logic [15:0] x, input logic k, input logic b);
    @(negedge clk);
    fv = !k; fa = x; fb = b; dv = k; da = x;
    @(negedge clk);
    fv = 1'b0; dv = 1'b0; fb = 1'b0;
    @(negedge clk);
  endtask
  // ****************************************
  // main sequence
  // ****************************************
  initial begin
    rstn = 1'b0; fv = 1'b0; fb = 1'b0; dv = 1'b0; cw = 1'b0; cd = 1'b0; cv = 1'b0;
    en = 1'b0; kd = 1'b0; hold = 1'b0; fa = 16'h0000; da = 16'h0000; ad = 16'h0000;
    iod = 8'h00; cmd = 4'h0; idx = 2'h0; seed = 32'h8e8e;
    repeat (16) @(negedge clk);
    rstn = 1'b1;
    send(obc_pkg::CMD_NOP, 2'h0, 1'b0, 1'b0, 16'h0000, r);
    check(24'(rst_edges), 24'h5);
    check(resp[23:22], 2'h0);
    repeat (6) begin
      seed = lfsr(seed);
      hit(seed[15:0], 1'b0, 1'b0);
    end
    check(halt, 1'b0);
    hit(seed[31:16], 1'b0, 1'b1);
    check(halt, 1'b1);
    check(pclk, 1'b1);
    d0 = disp_cnt;
    send(obc_pkg::CMD_START, 2'h0, 1'b0, 1'b0, 16'h0000, r);
    check(resp[23:22], 2'h3);
    send(obc_pkg::CMD_START, 2'h0, 1'b0, 1'b0, 16'h0000, r);
    check(halt, 1'b0);
    check(24'(disp_cnt - d0), 24'h1);
    for (int i = 0; i < 3; i++) begin
      seed = lfsr(seed);
      a = seed[15:0];
      send(obc_pkg::CMD_SET_BP, i[1:0], 1'b1, i[0], a, r);
      hit(a ^ 16'h8000, i[0], 1'b0);
      check(halt, 1'b0);
      hit(a, i[0], 1'b0);
      check(halt, 1'b1);
      send(obc_pkg::CMD_SET_BP, i[1:0], 1'b0, i[0], a, r);
      d0 = disp_cnt;
      send(obc_pkg::CMD_START, 2'h0, 1'b0, 1'b0, 16'h0000, r);
      check({halt, 23'(disp_cnt - d0)}, 24'h0);
      hit(a, i[0], 1'b0);
      check(halt, 1'b0);
    end
    send(obc_pkg::CMD_SET_BP, obc_pkg::STEP_BP, 1'b1, 1'b0, a, r);
    check(r, 1'b1);
    hit(a, 1'b0, 1'b1);
    seed = lfsr(seed);
    send(obc_pkg::UCMD_STEP, 2'h0, 1'b0, 1'b0, seed[15:0], r);
    check(halt, 1'b0);
    hit(seed[15:0], 1'b0, 1'b0);
    check(halt, 1'b1);
    // halted: io readout, the side-effect address refused
    a = {seed[31:24], 8'h20};
    iod = seed[23:16];
    d0 = iorq_cnt;
    send(obc_pkg::CMD_READ_IO, 2'h0, 1'b0, 1'b0, a, r);
    check({r, 7'(iorq_cnt - d0), ioa}, {8'h01, a});
    send(obc_pkg::CMD_READ_IO, 2'h0, 1'b0, 1'b0, obc_pkg::SKIP_IO_ADDR, r);
    check({r, 7'(iorq_cnt - d0)}, 8'h81);
    // read data rides in the response of the frame after the read
    send(obc_pkg::CMD_START, 2'h0, 1'b0, 1'b0, 16'h0000, r);
    check(resp[7:0], iod);
    // disable bit, then reset held by the probe
    @(negedge clk);
    cw = 1'b1; cd = 1'b1;
    @(negedge clk);
    cw = 1'b0;
    check(dis, 1'b1);
    send(obc_pkg::CMD_NOP, 2'h0, 1'b0, 1'b0, 16'h0000, r);
    check(resp, 24'hffffff);
    hold = 1'b1;
    repeat (20) @(negedge clk);
    cw = 1'b1;
    @(negedge clk);
    cw = 1'b0;
    repeat (20) @(negedge clk);
    check({link.srst_n, sens, crst, dis}, 24'h6);
    hold = 1'b0;
    repeat (40) @(negedge clk);
    check({sens, crst, dis, pclk}, 24'h1);
    send(obc_pkg::CMD_NOP, 2'h0, 1'b0, 1'b0, 16'h0000, r);
    check(resp[23:22], 2'h0);
    print_verdict();
  end
endmodule
`default_nettype wire
